// File: ldo_chan_regs.sv
// one regulator channel: voltage code and control byte storage
// assumes: decode of write strobes done by the parent
`timescale 1ns/1ps
`default_nettype none
module ldo_chan_regs
    import ldo_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset, high
    input wire logic vsel_we, // write voltage register
    input wire logic ctrl_we, // write control register
    input wire logic [7:0] wdata, // write data
    output var ldo_pkg::ldo_chan_ctl_t ctl // stored fields
);
    ldo_chan_ctl_t ctl_q;
    assign ctl = ctl_q;

    // ==============================================================
    // storage; upper voltage bits are never stored
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctl_q.output_level_code <= LDO_VSEL_RST;
            {ctl_q.regulator_on, ctl_q.output_bleed_enable, ctl_q.quiescent_saver_mode,
             ctl_q.turn_on_delay_code, ctl_q.fault_irq_allow} <= LDO_CTRL_RST;
        end else begin
            if (vsel_we) begin
                ctl_q.output_level_code <= wdata[5:0];
            end
            if (ctrl_we) begin
                ctl_q.regulator_on <= wdata[LDO_CTRL_ON_BIT];
                ctl_q.output_bleed_enable <= wdata[LDO_CTRL_BLEED_BIT];
                ctl_q.quiescent_saver_mode <= wdata[LDO_CTRL_SAVER_BIT];
                ctl_q.turn_on_delay_code <= wdata[LDO_CTRL_DLY_HI:LDO_CTRL_DLY_LO];
                ctl_q.fault_irq_allow <= wdata[LDO_CTRL_FLT_BIT];
            end
        end
    end
endmodule
`default_nettype wire

// File: ldo_pkg.sv
// package for the three-channel regulator control register bank
// assumes: one 8-bit register port, byte addresses as printed
package ldo_pkg;
    // ==============================================================
    // register map
    localparam logic [7:0] LDO_CH5_VSEL_ADDR = 8'h54;
    localparam logic [7:0] LDO_CH5_CTRL_ADDR = 8'h55;
    localparam logic [7:0] LDO_CH6_VSEL_ADDR = 8'h60;
    localparam logic [7:0] LDO_CH6_CTRL_ADDR = 8'h61;
    localparam logic [7:0] LDO_CH7_VSEL_ADDR = 8'h64;
    localparam logic [7:0] LDO_CH7_CTRL_ADDR = 8'h65;
    localparam logic [7:0] LDO_IRQ_STAT_ADDR = 8'h68;
    localparam logic [7:0] LDO_IRQ_MASK_ADDR = 8'h69;
    // ==============================================================
    // field positions and reset values
    localparam int LDO_CTRL_ON_BIT = 7;
    localparam int LDO_CTRL_BLEED_BIT = 6;
    localparam int LDO_CTRL_SAVER_BIT = 5;
    localparam int LDO_CTRL_DLY_HI = 4;
    localparam int LDO_CTRL_DLY_LO = 2;
    localparam int LDO_CTRL_FLT_BIT = 1;
    localparam int LDO_CTRL_PG_BIT = 0;
    localparam int LDO_NUM_CH = 3;
    localparam logic [5:0] LDO_VSEL_RST = 6'h00;
    localparam logic [6:0] LDO_CTRL_RST = 7'h00;
    localparam logic [2:0] LDO_MASK_RST = 3'h0;

    // one channel's control outputs toward the analog regulator
    typedef struct packed {
        logic [5:0] output_level_code;
        logic regulator_on;
        logic output_bleed_enable;
        logic quiescent_saver_mode;
        logic [2:0] turn_on_delay_code;
        logic fault_irq_allow;
    } ldo_chan_ctl_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ldo_req_t;
endpackage

// File: ldo_regs.sv
// register bank for three regulator channels with fault interrupt
// assumes: single clock, 8-bit register port, analog status synchronous
`timescale 1ns/1ps
`default_nettype none
module ldo_regs
    import ldo_pkg::*;
(
    input wire logic sys_clk, // 10 MHz clock
    input wire logic rst, // synchronous reset, high
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic [2:0] power_good, // per-channel power good
    input wire logic [2:0] fault, // per-channel fault events
    output var ldo_pkg::ldo_chan_ctl_t ch5_ctl, // channel 5 controls
    output var ldo_pkg::ldo_chan_ctl_t ch6_ctl, // channel 6 controls
    output var ldo_pkg::ldo_chan_ctl_t ch7_ctl, // channel 7 controls
    output logic irq // level interrupt
);
    import ldo_pkg::*;

    // ==============================================================
    // address decode
    ldo_req_t req;
    ldo_chan_ctl_t ctl [LDO_NUM_CH];
    logic [7:0] vsel_addr [LDO_NUM_CH];
    logic [7:0] ctrl_addr [LDO_NUM_CH];
    logic [7:0] rdata_d, rdata_q;
    logic [2:0] stat_q, stat_d, mask_q;
    logic [2:0] fault_ev;
    wire stat_rd;
    wire mask_wr;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign vsel_addr[0] = LDO_CH5_VSEL_ADDR;
    assign vsel_addr[1] = LDO_CH6_VSEL_ADDR;
    assign vsel_addr[2] = LDO_CH7_VSEL_ADDR;
    assign ctrl_addr[0] = LDO_CH5_CTRL_ADDR;
    assign ctrl_addr[1] = LDO_CH6_CTRL_ADDR;
    assign ctrl_addr[2] = LDO_CH7_CTRL_ADDR;
    assign stat_rd = req.rd && (req.addr == LDO_IRQ_STAT_ADDR);
    assign mask_wr = req.wr && (req.addr == LDO_IRQ_MASK_ADDR);

    // control byte as read: stored fields plus live power good
    function automatic logic [7:0] ctrl_byte(input ldo_chan_ctl_t c, input logic pg);
        ctrl_byte = {c.regulator_on, c.output_bleed_enable, c.quiescent_saver_mode,
                     c.turn_on_delay_code, c.fault_irq_allow, pg};
    endfunction

    // ==============================================================
    // channel storage
    genvar g;
    generate
        for (g = 0; g < LDO_NUM_CH; g++) begin : g_ch
            ldo_chan_regs u_ch (
                .sys_clk(sys_clk),
                .rst(rst),
                .vsel_we(req.wr && (req.addr == vsel_addr[g])),
                .ctrl_we(req.wr && (req.addr == ctrl_addr[g])),
                .wdata(req.wdata),
                .ctl(ctl[g])
            );
            // faults count only when the channel allows them
            assign fault_ev[g] = fault[g] && ctl[g].fault_irq_allow;
        end
    endgenerate

    assign ch5_ctl = ctl[0];
    assign ch6_ctl = ctl[1];
    assign ch7_ctl = ctl[2];

    // ==============================================================
    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 8'h00;
        case (req.addr)
            LDO_CH5_VSEL_ADDR: rdata_d = {2'h0, ctl[0].output_level_code};
            LDO_CH6_VSEL_ADDR: rdata_d = {2'h0, ctl[1].output_level_code};
            LDO_CH7_VSEL_ADDR: rdata_d = {2'h0, ctl[2].output_level_code};
            LDO_CH5_CTRL_ADDR: rdata_d = ctrl_byte(ctl[0], power_good[0]);
            LDO_CH6_CTRL_ADDR: rdata_d = ctrl_byte(ctl[1], power_good[1]);
            LDO_CH7_CTRL_ADDR: rdata_d = ctrl_byte(ctl[2], power_good[2]);
            LDO_IRQ_STAT_ADDR: rdata_d = {5'h00, stat_q};
            LDO_IRQ_MASK_ADDR: rdata_d = {5'h00, mask_q};
            default: rdata_d = 8'h00;
        endcase
    end

    // sticky status: a new event wins over the clearing read
    assign stat_d = (stat_rd ? 3'h0 : stat_q) | fault_ev;

    // ==============================================================
    // status, mask and read data registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stat_q <= 3'h0;
            mask_q <= LDO_MASK_RST;
            rdata_q <= 8'h00;
        end else begin
            stat_q <= stat_d;
            if (mask_wr) begin
                mask_q <= req.wdata[2:0];
            end
            // read data stand only in the cycle after the strobe
            rdata_q <= req.rd ? rdata_d : 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = |(stat_q & mask_q);
endmodule
`default_nettype wire

// File: ldo_regs_monitor.sv
// checker for the regulator register bank
// assumes: bound to ldo_regs, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module ldo_regs_mon
    import ldo_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic rst, // reset, high
    input wire logic [7:0] reg_addr, // address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_rdata, // read data
    input wire logic [2:0] power_good, // power good
    input wire logic [2:0] fault, // faults
    input wire ldo_pkg::ldo_chan_ctl_t ch5_ctl, // ch5
    input wire ldo_pkg::ldo_chan_ctl_t ch6_ctl, // ch6
    input wire ldo_pkg::ldo_chan_ctl_t ch7_ctl, // ch7
    input wire logic irq // interrupt
);
    // ==============================================================
    // helpers: an irq may only rise after an allowed fault or a mask write
    wire logic cause_w = |(fault & {ch7_ctl.fault_irq_allow, ch6_ctl.fault_irq_allow,
        ch5_ctl.fault_irq_allow}) || (reg_wr && reg_addr == LDO_IRQ_MASK_ADDR);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence wr_at(logic [7:0] a); reg_wr && reg_addr == a; endsequence
    sequence rd_at(logic [7:0] a); reg_rd && reg_addr == a; endsequence
    // ==============================================================
    // properties
    lvl_write_a: assert property (wr_at(LDO_CH5_VSEL_ADDR) |=>
        ch5_ctl.output_level_code == $past(reg_wdata[5:0])) else $error("level code");
    on_write_a: assert property (wr_at(LDO_CH5_CTRL_ADDR) |=>
        ch5_ctl.regulator_on == $past(reg_wdata[7])) else $error("on bit");
    bleed_write_a: assert property (wr_at(LDO_CH6_CTRL_ADDR) |=>
        ch6_ctl.output_bleed_enable == $past(reg_wdata[6])) else $error("bleed bit");
    saver_write_a: assert property (wr_at(LDO_CH7_CTRL_ADDR) |=>
        ch7_ctl.quiescent_saver_mode == $past(reg_wdata[5])) else $error("saver bit");
    delay_write_a: assert property (wr_at(LDO_CH5_CTRL_ADDR) |=>
        ch5_ctl.turn_on_delay_code == $past(reg_wdata[4:2])) else $error("delay code");
    irq_cause_a: assert property ($rose(irq) |-> $past(cause_w))
        else $error("irq without cause");
    pg_read_a: assert property (rd_at(LDO_CH6_CTRL_ADDR) |=>
        reg_rdata[0] == $past(power_good[1])) else $error("power good read");
    vsel_rsvd_a: assert property (rd_at(LDO_CH7_VSEL_ADDR) |=>
        reg_rdata[7:6] == 2'h0) else $error("reserved bits");
endmodule
bind ldo_regs ldo_regs_mon i_mon (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .power_good(power_good), .fault(fault), .ch5_ctl(ch5_ctl), .ch6_ctl(ch6_ctl),
    .ch7_ctl(ch7_ctl), .irq(irq));
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the regulator register bank
// assumes: ldo_regs with its monitor bound, one 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ldo_pkg::*;
    logic sys_clk, rst, reg_wr, reg_rd, rd_q, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] power_good, fault;
    ldo_chan_ctl_t ctl [3];
    logic [7:0] vs [3], cs [3];
    logic [7:0] va [3] = '{LDO_CH5_VSEL_ADDR, LDO_CH6_VSEL_ADDR, LDO_CH7_VSEL_ADDR};
    logic [7:0] exp_q [$];
    int miscompares = 0, total_checks = 0;
    ldo_regs i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_good(power_good),
        .fault(fault), .ch5_ctl(ctl[0]), .ch6_ctl(ctl[1]), .ch7_ctl(ctl[2]), .irq(irq));
    // ==============================================================
    // clock, compare and bus tasks
    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] v);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
    endtask
    task automatic idle;
        bus(1'h0, 1'h0, 8'h00, 8'h00);
    endtask
    // the note is queued as the read is issued
    task automatic rd(logic [7:0] a, logic [7:0] e);
        exp_q.push_back(e);
        bus(1'h0, 1'h1, a, 8'h00);
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==============================================================
    // read data stands only in the cycle after the strobe
    always @(posedge sys_clk) begin
        rd_q <= reg_rd;
        if (rd_q) chk("rdata", exp_q.pop_front(), reg_rdata);
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        miscompares++;
        wrap_up;
    end
    // ==============================================================
    // main sequence
    initial begin
        void'($urandom(32'h797B42A3));
        {reg_wr, reg_rd, reg_addr, reg_wdata, fault, power_good} <= '0;
        rst <= 1'h1;
        repeat (12) @(posedge sys_clk);
        rst <= 1'h0;
        foreach (va[i]) rd(va[i] + 8'h01, 8'h00);
        power_good <= 3'($urandom);
        // random bytes, reserved and read-only bits set on purpose
        repeat (4) begin
            foreach (va[i]) begin
                vs[i] = 8'($urandom);
                cs[i] = 8'($urandom);
                bus(1'h1, 1'h0, va[i], vs[i]);
                bus(1'h1, 1'h0, va[i] + 8'h01, cs[i]);
            end
            bus(1'h1, 1'h0, 8'h56, 8'hFF);
            idle();
            #1;
            foreach (va[i]) begin
                chk("ctl", {vs[i][5:0], cs[i][7:1]}, ctl[i]);
                rd(va[i], {2'h0, vs[i][5:0]});
                rd(va[i] + 8'h01, {cs[i][7:1], power_good[i]});
            end
            rd(8'h56, 8'h00);
        end
        // fault on ch5 with capture off, ch6 allowed and unmasked
        bus(1'h1, 1'h0, LDO_CH5_CTRL_ADDR, 8'h00);
        bus(1'h1, 1'h0, LDO_CH6_CTRL_ADDR, 8'h02);
        bus(1'h1, 1'h0, LDO_IRQ_MASK_ADDR, 8'h02);
        foreach (va[i]) begin
            fault <= (i == 0) ? 3'h3 : 3'h2;
            idle();
            fault <= 3'h0;
            idle();
            #1;
            chk("irq", (i == 0) ? 1'h1 : 1'h0, irq);
            rd(LDO_IRQ_STAT_ADDR, 8'h02);
            rd(LDO_IRQ_STAT_ADDR, 8'h00);
            bus(1'h1, 1'h0, LDO_IRQ_MASK_ADDR, 8'h00);
        end
        // mid-run reset with a pending interrupt: fields, status and mask all clear
        bus(1'h1, 1'h0, LDO_IRQ_MASK_ADDR, 8'h07);
        fault <= 3'h2;
        idle();
        fault <= 3'h0;
        rst <= 1'h1;
        idle();
        idle();
        rst <= 1'h0;
        #1;
        chk("irq", 1'h0, irq);
        rd(LDO_CH5_VSEL_ADDR, 8'h00);
        rd(LDO_CH6_CTRL_ADDR, {7'h00, power_good[1]});
        rd(LDO_IRQ_STAT_ADDR, 8'h00);
        rd(LDO_IRQ_MASK_ADDR, 8'h00);
        idle();
        idle();
        wrap_up;
    end
endmodule
`default_nettype wire
